// ===== fsy_map.vh
`ifndef FSY_MAP_VH
`define FSY_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FSY_CHAN_A_FREQ_OFS 16'hFE0A
`define FSY_CHAN_B_FREQ_OFS 16'hFE0B
`define FSY_CHAN_C_FREQ_OFS 16'hFE0C
`define FSY_SRC_SEL_OFS 16'hFE0E
`define FSY_PIN_CFG_OFS 16'hFE0F

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define FSY_MULT_HI 7
`define FSY_MULT_LO 6
`define FSY_SYNC_EN_BIT 5
`define FSY_SRC_C_BIT 3
`define FSY_SYNC_REFERENCE_OUTPUT_EN_BIT 3
`define FSY_EXTERNAL_SYNC_INPUT_EN_BIT 2
`define FSY_REG_RESET 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FSY_CLK_MHZ 250
`define FSY_PULSE_NS 320
`define FSY_LEAD_NS 760
`define FSY_TIMEOUT_US 80
`define FSY_PULSE_CYC ((`FSY_PULSE_NS * `FSY_CLK_MHZ) / 1000)
`define FSY_LEAD_CYC ((`FSY_LEAD_NS * `FSY_CLK_MHZ) / 1000)
`define FSY_TIMEOUT_CYC (`FSY_TIMEOUT_US * `FSY_CLK_MHZ)

`endif

// ===== fsy_freq_sync.v
`timescale 1ns/100ps
`include "fsy_map.vh"

module fsy_freq_sync #(
  parameter PW = 20,
  parameter TIMEOUT_CYC = `FSY_TIMEOUT_CYC,
  parameter LOCK_COUNT = 2
) (
  // Clock and reset.
  input wire core_clk,
  input wire srst,
  // Register write and read port.
  input wire reg_wr,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Preset periods of each channel in core cycles, from the PWM engine.
  input wire [PW-1:0] chan_a_period,
  input wire [PW-1:0] chan_b_period,
  input wire [PW-1:0] chan_c_period,
  // Pins.
  input wire flag_or_sync_input_pin,
  output reg flag_or_sync_output_pin,
  // Flag path.
  input wire flag_output_function,
  output reg flag_input_function,
  // Sync status towards the channels.
  output reg sync_locked,
  output reg ext_sync_edge,
  output reg [1:0] ref_chan
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg [7:0] chan_a_switching_frequency_q; // Channel A frequency register.
  reg [7:0] chan_b_switching_frequency_q; // Channel B frequency register.
  reg [7:0] chan_c_switching_frequency_q; // Channel C frequency register.
  reg [7:0] sync_source_select_q; // Sync output source select.
  reg [7:0] flag_sync_pin_config_q; // Shared pin configuration.

  // Plain write port; an unknown address is ignored.
  always @(posedge core_clk) begin
    if (srst) begin
      chan_a_switching_frequency_q <= `FSY_REG_RESET;
      chan_b_switching_frequency_q <= `FSY_REG_RESET;
      chan_c_switching_frequency_q <= `FSY_REG_RESET;
      sync_source_select_q <= `FSY_REG_RESET;
      flag_sync_pin_config_q <= `FSY_REG_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `FSY_CHAN_A_FREQ_OFS: chan_a_switching_frequency_q <= reg_wdata;
        `FSY_CHAN_B_FREQ_OFS: chan_b_switching_frequency_q <= reg_wdata;
        `FSY_CHAN_C_FREQ_OFS: chan_c_switching_frequency_q <= reg_wdata;
        `FSY_SRC_SEL_OFS: sync_source_select_q <= reg_wdata;
        `FSY_PIN_CFG_OFS: flag_sync_pin_config_q <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read data is registered; unmapped addresses read zero.
  always @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `FSY_CHAN_A_FREQ_OFS: reg_rdata <= chan_a_switching_frequency_q;
        `FSY_CHAN_B_FREQ_OFS: reg_rdata <= chan_b_switching_frequency_q;
        `FSY_CHAN_C_FREQ_OFS: reg_rdata <= chan_c_switching_frequency_q;
        `FSY_SRC_SEL_OFS: reg_rdata <= sync_source_select_q;
        `FSY_PIN_CFG_OFS: reg_rdata <= flag_sync_pin_config_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sync output generator
  // ----------------------------------------------------------------------
  localparam [PW-1:0] PULSE_CYC = `FSY_PULSE_CYC; // 80 cycles high.
  localparam [PW-1:0] LEAD_CYC = `FSY_LEAD_CYC; // 190 cycles ahead.

  wire sync_reference_output_en = flag_sync_pin_config_q[`FSY_SYNC_REFERENCE_OUTPUT_EN_BIT];
  // The output always follows the preset period, never the imposed one.
  wire [PW-1:0] out_period = sync_source_select_q[`FSY_SRC_C_BIT] ? chan_c_period : chan_a_period;
  reg [PW-1:0] out_cnt_q; // Position inside the reference cycle.
  reg [PW-1:0] pulse_cnt_q; // Remaining high cycles of the pulse.
  // The pulse starts this far before the wrap so that it leads the cycle start.
  wire [PW-1:0] lead_point = (out_period > LEAD_CYC) ? out_period - LEAD_CYC : {PW{1'b0}};

  // Free-running reference cycle counter and pulse stretcher.
  always @(posedge core_clk) begin
    if (srst || !sync_reference_output_en) begin
      out_cnt_q <= {PW{1'b0}};
      pulse_cnt_q <= {PW{1'b0}};
    end else begin
      if (out_cnt_q + 1'b1 >= out_period) begin
        out_cnt_q <= {PW{1'b0}};
      end else begin
        out_cnt_q <= out_cnt_q + 1'b1;
      end
      if (out_cnt_q == lead_point) begin
        pulse_cnt_q <= PULSE_CYC;
      end else if (pulse_cnt_q != {PW{1'b0}}) begin
        pulse_cnt_q <= pulse_cnt_q - 1'b1;
      end
    end
  end

  // The shared pin carries either the flag or the sync pulse.
  always @(posedge core_clk) begin
    if (srst) begin
      flag_or_sync_output_pin <= 1'b0;
    end else if (sync_reference_output_en) begin
      flag_or_sync_output_pin <= (pulse_cnt_q != {PW{1'b0}});
    end else begin
      flag_or_sync_output_pin <= flag_output_function;
    end
  end

  // ----------------------------------------------------------------------
  // Reference channel choice
  // ----------------------------------------------------------------------
  wire en_a = chan_a_switching_frequency_q[`FSY_SYNC_EN_BIT];
  wire en_b = chan_b_switching_frequency_q[`FSY_SYNC_EN_BIT];
  wire en_c = chan_c_switching_frequency_q[`FSY_SYNC_EN_BIT];
  wire [1:0] mul_a = chan_a_switching_frequency_q[`FSY_MULT_HI:`FSY_MULT_LO];
  wire [1:0] mul_b = chan_b_switching_frequency_q[`FSY_MULT_HI:`FSY_MULT_LO];
  wire [1:0] mul_c = chan_c_switching_frequency_q[`FSY_MULT_HI:`FSY_MULT_LO];
  reg [1:0] sel; // Chosen channel, 0 = A, 1 = B, 2 = C.
  reg [1:0] sel_mul; // Its multiple code.
  reg [PW-1:0] sel_period; // Its preset period.

  // Strict less-than keeps the earlier channel on a tie, giving A over B over C.
  always @* begin
    sel = 2'd0;
    sel_mul = mul_a;
    sel_period = chan_a_period;
    if (en_b && (!en_a || mul_b < mul_a)) begin
      sel = 2'd1;
      sel_mul = mul_b;
      sel_period = chan_b_period;
    end
    if (en_c && ((!en_a && !en_b) || mul_c < sel_mul)) begin
      sel = 2'd2;
      sel_mul = mul_c;
      sel_period = chan_c_period;
    end
  end

  // Expected external period is the channel period times its multiple.
  // A code of zero means multiple one; software must set one channel so.
  // Both factors are widened to the product width so that nothing is padded silently.
  wire [PW+1:0] exp_period = {2'b00, sel_period} * {{(PW-1){1'b0}}, {1'b0, sel_mul} + 3'd1};

  // ----------------------------------------------------------------------
  // Sync input measurement
  // ----------------------------------------------------------------------
  wire external_sync_input_en = flag_sync_pin_config_q[`FSY_EXTERNAL_SYNC_INPUT_EN_BIT];
  wire any_en = en_a | en_b | en_c;
  reg in_meta_q; // First synchroniser stage.
  reg in_sync_q; // Second synchroniser stage.
  reg in_prev_q; // Previous value for edge detection.
  reg [PW+1:0] meas_q; // Cycles since the last rising edge.
  reg [PW+1:0] idle_q; // Timeout counter.
  reg [3:0] good_q; // Consecutive in-window periods.
  reg seen_q; // A first edge has opened a measurement.

  // Two flops before any logic looks at the pin.
  always @(posedge core_clk) begin
    if (srst) begin
      in_meta_q <= 1'b0;
      in_sync_q <= 1'b0;
      in_prev_q <= 1'b0;
    end else begin
      in_meta_q <= flag_or_sync_input_pin;
      in_sync_q <= in_meta_q;
      in_prev_q <= in_sync_q;
    end
  end

  wire rise = in_sync_q & ~in_prev_q;
  wire [PW+1:0] meas_now = meas_q + 1'b1;
  // Frequency window 90..110 percent, as period: 10P/11 <= T <= 10P/9.
  wire [PW+5:0] t11 = {4'h0, meas_now} * {{(PW+2){1'b0}}, 4'hB};
  wire [PW+5:0] t9 = {4'h0, meas_now} * {{(PW+2){1'b0}}, 4'h9};
  wire [PW+5:0] p10 = {4'h0, exp_period} * {{(PW+2){1'b0}}, 4'hA};
  wire in_window = (t11 >= p10) && (t9 <= p10);
  localparam [PW+1:0] TOUT = TIMEOUT_CYC;
  localparam [3:0] LOCK_N = LOCK_COUNT;

  // Period measurement, timeout and lock state.
  always @(posedge core_clk) begin
    if (srst || !external_sync_input_en || !any_en) begin
      meas_q <= {(PW+2){1'b0}};
      idle_q <= {(PW+2){1'b0}};
      good_q <= 4'd0;
      seen_q <= 1'b0;
      sync_locked <= 1'b0;
    end else if (rise) begin
      meas_q <= {(PW+2){1'b0}};
      idle_q <= {(PW+2){1'b0}};
      seen_q <= 1'b1;
      if (seen_q && in_window) begin
        if (good_q >= LOCK_N - 1'b1) begin
          sync_locked <= 1'b1;
        end else begin
          good_q <= good_q + 1'b1;
        end
      end else begin
        good_q <= 4'd0;
        sync_locked <= 1'b0;
      end
    end else begin
      meas_q <= meas_now;
      if (idle_q + 1'b1 >= TOUT) begin
        idle_q <= {(PW+2){1'b0}};
        good_q <= 4'd0;
        seen_q <= 1'b0;
        sync_locked <= 1'b0;
      end else begin
        idle_q <= idle_q + 1'b1;
      end
    end
  end

  // Edge strobe, reference index and flag input path.
  always @(posedge core_clk) begin
    if (srst) begin
      ext_sync_edge <= 1'b0;
      ref_chan <= 2'd0;
      flag_input_function <= 1'b0;
    end else begin
      ext_sync_edge <= rise & sync_locked;
      ref_chan <= sel;
      flag_input_function <= external_sync_input_en ? 1'b0 : in_sync_q;
    end
  end

endmodule // fsy_freq_sync

// ===== fsy_freq_sync_chk.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module fsy_chk #(
  parameter TIMEOUT_CYC = 200
) (
  // Clock and register writes.
  input wire core_clk,
  input wire srst,
  input wire reg_wr,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  // Pins and status.
  input wire flag_or_sync_input_pin,
  input wire flag_or_sync_output_pin,
  input wire flag_output_function,
  input wire flag_input_function,
  input wire sync_locked,
  input wire ext_sync_edge,
  input wire [1:0] ref_chan
);
  reg [7:0] cfg_q; // Shadow of the pin configuration.
  reg [7:0] hi_q; // Cycles the output pin has stood high.
  reg [15:0] gap_q; // Cycles since the last input rise, saturating.
  reg [7:0] fa_q; // Shadow of the channel A frequency register.
  reg [7:0] fb_q; // Shadow of the channel B frequency register.
  reg [7:0] fc_q; // Shadow of the channel C frequency register.
  // Rank of each channel: its multiple code when enabled, 4 when it takes no part.
  wire [2:0] ka = fa_q[5] ? {1'b0, fa_q[7:6]} : 3'h4;
  wire [2:0] kb = fb_q[5] ? {1'b0, fb_q[7:6]} : 3'h4;
  wire [2:0] kc = fc_q[5] ? {1'b0, fc_q[7:6]} : 3'h4;
  wire [2:0] kmin = (ka < kb) ? ((ka < kc) ? ka : kc) : ((kb < kc) ? kb : kc); // Lowest rank.
  // The first channel in A, B, C order that holds the lowest rank is the reference.
  wire [1:0] exp_ref = (ka == kmin) ? 2'h0 : (kb == kmin) ? 2'h1 : (kc == kmin) ? 2'h2 : 2'h0;
  // The shadows let pin rules be gated on the mode without peeking inside.
  always @(posedge core_clk) begin
    if (srst) begin
      cfg_q <= 8'h00;
      hi_q <= 8'h00;
      gap_q <= 16'h0000;
      fa_q <= 8'h00;
      fb_q <= 8'h00;
      fc_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == 16'hFE0F) cfg_q <= reg_wdata;
      if (reg_wr && reg_addr == 16'hFE0A) fa_q <= reg_wdata;
      if (reg_wr && reg_addr == 16'hFE0B) fb_q <= reg_wdata;
      if (reg_wr && reg_addr == 16'hFE0C) fc_q <= reg_wdata;
      hi_q <= flag_or_sync_output_pin ? hi_q + 8'h01 : 8'h00;
      gap_q <= $rose(flag_or_sync_input_pin) ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_hi_end; $fell(flag_or_sync_output_pin); endsequence
  sequence s_fresh; gap_q < 16'h0008; endsequence
  property p_pulse_w; cfg_q[3] && $past(cfg_q[3], 90) ##0 s_hi_end |-> hi_q == 8'h50; endproperty
  property p_flag_pass; !cfg_q[3] && !$past(cfg_q[3]) && !$past(srst)
    |-> flag_or_sync_output_pin == $past(flag_output_function); endproperty
  property p_fin_zero; cfg_q[2] && $past(cfg_q[2]) |-> !flag_input_function; endproperty
  // The edge strobe lags the lock state by one more flop, hence the extra cycle of history.
  property p_fin_off; !cfg_q[2] && !$past(cfg_q[2]) && !$past(cfg_q[2], 2) |-> !sync_locked && !ext_sync_edge;
  endproperty
  // Pin sampled high three edges back: two synchroniser flops plus the strobe flop.
  property p_edge_lk; ext_sync_edge |-> $past(sync_locked) && $past(flag_or_sync_input_pin, 3); endproperty
  property p_to; sync_locked |-> gap_q < TIMEOUT_CYC + 8; endproperty
  property p_lock; $rose(sync_locked) |-> s_fresh; endproperty
  property p_ref; ref_chan == $past(exp_ref); endproperty
  a_pulse_w: assert property (p_pulse_w) else $error("sync pulse width wrong");
  a_flag_pass: assert property (p_flag_pass) else $error("flag not passed to pin");
  a_fin_zero: assert property (p_fin_zero) else $error("flag input not blocked");
  a_fin_off: assert property (p_fin_off) else $error("sync active in flag mode");
  a_edge_lk: assert property (p_edge_lk) else $error("edge pulse without cause");
  a_to: assert property (p_to) else $error("lock held through silence");
  a_lock: assert property (p_lock) else $error("lock without fresh edge");
  a_ref: assert property (p_ref) else $error("reference channel not the lowest multiple");
endmodule // fsy_chk

// ===== fsy_sync_src.sv
`timescale 1ns/100ps
module fsy_sync_src (
  // Control from the bench.
  input wire run,
  input wire [7:0] half_ns,
  // Sync clock towards the device.
  output reg pin
);
  // The ceiling on the sync rate is advisory only; the bench scales all periods down together.
  // The clock stands low outside a run; the start offset keeps it off the core edges.
  initial begin
    pin = 1'b0;
    forever begin
      if (run) begin
        #(half_ns) pin = ~pin;
      end else begin
        pin = 1'b0;
        @(posedge run);
        #1.3;
      end
    end
  end
endmodule // fsy_sync_src

// ===== fsy_freq_sync_tb_top.sv
`timescale 1ns/100ps
module fsy_freq_sync_tb_top;
  reg core_clk = 1'b0;
  reg srst = 1'b1;
  reg reg_wr = 1'b0;
  reg [15:0] reg_addr = 16'h0000;
  reg [7:0] reg_wdata = 8'h00;
  reg flag_out_q = 1'b0; // Random flag sent while sync output is off.
  reg run = 1'b0;
  reg [7:0] half = 8'h28; // Half period of the link clock in ns.
  reg [31:0] rs = 32'h3FAC95E8;
  reg [23:0] v;
  wire [7:0] rdata;
  wire pin_in, pin_out, fin, lk, edg;
  wire [1:0] rc;
  integer bad_count = 0;
  integer comparisons = 0;
  integer cnt, w, i;
  always #2 core_clk = ~core_clk;
  fsy_freq_sync #(.TIMEOUT_CYC(200)) fsy_freq_sync_inst (.core_clk(core_clk), .srst(srst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .chan_a_period(20'h0012C),
    .chan_b_period(20'h00014), .chan_c_period(20'h00190), .flag_or_sync_input_pin(pin_in),
    .flag_or_sync_output_pin(pin_out), .flag_output_function(flag_out_q), .flag_input_function(fin),
    .sync_locked(lk), .ext_sync_edge(edg), .ref_chan(rc));
  fsy_sync_src fsy_sync_src_inst (.run(run), .half_ns(half), .pin(pin_in));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // Lowest enabled multiple wins; strict less keeps the earlier channel on a tie.
  function [1:0] ref_of(input [23:0] c);
    integer k;
    reg [1:0] m, r;
    reg f;
    begin
      r = 2'h0;
      m = 2'h3;
      f = 1'b0;
      for (k = 0; k < 3; k = k + 1) begin
        if (c[21-8*k] && (!f || c[23-8*k -: 2] < m)) begin
          r = k[1:0];
          m = c[23-8*k -: 2];
          f = 1'b1;
        end
      end
      ref_of = r;
    end
  endfunction
  task cmp(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %0h, expected %0h", $time, g, e);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      reg_addr = a;
      repeat (2) @(negedge core_clk);
      cmp(rdata, e);
    end
  endtask
  // Bounded wait for the output pin (s=0) or the lock flag (s=1).
  task wt(input s, input val);
    begin
      cnt = 0;
      while (((s ? lk : pin_out) !== val) && cnt < 3000) begin
        @(negedge core_clk);
        cnt = cnt + 1;
      end
      if (cnt >= 3000) begin
        cmp(cnt, 0);
        tally_and_finish;
      end
    end
  endtask
  // Pulse width and rise-to-rise spacing of the sync output.
  task meas(input integer p);
    begin
      wt(1'b0, 1'b0);
      wt(1'b0, 1'b1);
      wt(1'b0, 1'b0);
      w = cnt;
      wt(1'b0, 1'b1);
      cmp(w, 80);
      cmp(w + cnt, p);
    end
  endtask
  // Count the samples in 40 cycles at which fin (s=1) or edg (s=0) stands high.
  task sum40(input s);
    begin
      w = 0;
      repeat (40) begin
        @(negedge core_clk);
        w = w + (s ? fin : edg);
      end
    end
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    srst = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      rd(16'hFE0A + i[15:0], 8'h00);
    end
    wr(16'hFE0F, 8'h08);
    meas(300);
    wr(16'hFE0E, 8'h08);
    meas(400);
    wr(16'hFE0E, 8'h00);
    wr(16'hFE0A, 8'h60);
    wr(16'hFE0B, 8'h20);
    wr(16'hFE0F, 8'h0C);
    run = 1'b1;
    wt(1'b1, 1'b1);
    cmp(rc, 1);
    sum40(1'b0);
    cmp(w, 2);
    meas(300);
    half = 8'h34;
    wt(1'b1, 1'b0);
    half = 8'h28;
    wt(1'b1, 1'b1);
    run = 1'b0;
    wt(1'b1, 1'b0);
    cmp(cnt > 150 && cnt < 230, 1);
    run = 1'b1;
    wr(16'hFE0F, 8'h08);
    repeat (100) @(negedge core_clk);
    cmp(lk, 0);
    sum40(1'b1);
    cmp(w, 20);
    run = 1'b0;
    wr(16'hFE0F, 8'h04);
    for (i = 0; i < 24; i = i + 1) begin
      rs = xs(rs);
      v = (i == 0) ? 24'h202020 : rs[23:0];
      flag_out_q = rs[31];
      wr(16'hFE0A, v[23:16]);
      wr(16'hFE0B, v[15:8]);
      wr(16'hFE0C, v[7:0]);
      rd(16'hFE0C, v[7:0]);
      cmp(rc, ref_of(v));
      cmp(pin_out, flag_out_q);
    end
    tally_and_finish;
  end
endmodule // fsy_freq_sync_tb_top
bind fsy_freq_sync fsy_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) fsy_chk_inst (.core_clk(core_clk), .srst(srst),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .flag_or_sync_input_pin(flag_or_sync_input_pin),
  .flag_or_sync_output_pin(flag_or_sync_output_pin), .flag_output_function(flag_output_function),
  .flag_input_function(flag_input_function), .sync_locked(sync_locked), .ext_sync_edge(ext_sync_edge),
  .ref_chan(ref_chan));
